// ### hw/atc_defines.vh
// constants for the acquisition and frame trigger controller
// assumes a 10 MHz pclk and a 32-bit apb register bus
`ifndef ATC_DEFINES_VH
`define ATC_DEFINES_VH
// register byte offsets
`define ATC_OFS_CTRL 8'h00
`define ATC_OFS_CMD 8'h04
`define ATC_OFS_TARGET 8'h08
`define ATC_OFS_REGION 8'h0c
`define ATC_OFS_ACHIEVE 8'h10
`define ATC_OFS_STATUS 8'h14
// control field positions
`define ATC_CTRL_FAST 0
`define ATC_CTRL_UNLIMIT 1
`define ATC_CTRL_ACQ_EN 2
`define ATC_CTRL_ACQ_TRIG 3
`define ATC_CTRL_FRM_TRIG 4
`define ATC_CTRL_TGT_EN 5
`define ATC_CTRL_EDGE 6
`define ATC_CTRL_ORIGIN_LO 8
`define ATC_CTRL_ORIGIN_HI 9
`define ATC_CTRL_MASK 32'h0000037f
// trigger origin and edge codes
`define ATC_ORIGIN_LINE_ONE 2'h0
`define ATC_EDGE_RISING 1'b0
// reset values
`define ATC_CTRL_RST 32'h00000000
`define ATC_TARGET_RST 32'h00000000
`define ATC_REGION_RST 16'h01e0
// timing: line time in cycles per readout speed, plus fixed frame overhead
`define ATC_LINE_NORMAL 8'h14
`define ATC_LINE_FAST 8'h0c
`define ATC_FRAME_OVERHEAD 32'h00000040
`endif

// ### hw/atc_frame_timer.v
// cycle counter timed from the last frame start
// assumes start pulses come from the trigger controller, one clock
module atc_frame_timer
(
   input wire pclk,
   input wire presetn,
   input wire start,
   output wire [31:0] elapsed
);
   reg [31:0] cnt_r;
   reg [31:0] cnt_nxt;

   // restart on frame start, otherwise count and saturate
   always @*
   begin
      if (start)
         cnt_nxt = 32'h00000001;
      else if (cnt_r != 32'hffffffff)
         cnt_nxt = cnt_r + 32'h00000001;
      else
         cnt_nxt = cnt_r;
   end

   // starts saturated so the first free-run frame goes at once
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnt_r <= 32'hffffffff;
      else
         cnt_r <= cnt_nxt;
   end

   assign elapsed = cnt_r;
endmodule

// ### hw/atc_trigger_ctrl.v
// acquisition and frame trigger controller with apb register access
// assumes input_line_one is synchronous to pclk; one clock, async reset
//
// How it works
// - two readout speeds, normal after reset
// - fast readout shortens line time, raising the frame rate
// - limit removal shortens line time by a quarter at either speed
// - achievable frame period register follows limit state
// - free run makes all frame starts internally; acquisition start still follows its trigger
// - free run paces at target period unless minimum period is longer
// - target disabled means frames at the minimum period
// - acquisition trigger off means acquisition starts itself
// - frame trigger on starts one exposure per received trigger
// - selected edge on input line one is the frame trigger
// - a triggered frame runs and is handed on as frame_valid
// - frame triggers only taken while waiting for a frame start
//
// register map, one aligned 32-bit word per offset
//    0x00 control word
//       bit 0 fast readout, bit 1 frame-rate limit removed
//       bit 2 acquisition enable, continuous acquisition
//       bit 3 acquisition start trigger enable
//       bit 4 frame start trigger enable
//       bit 5 target frame period enable
//       bit 6 trigger edge, 0 rising, 1 falling
//       bits 9:8 trigger origin, 0 input line one, others never fire
//    0x04 command: bit 0 starts acquisition, reads zero
//    0x08 target frame period in clock cycles
//    0x0c image region height in lines
//    0x10 achievable frame period in clock cycles, read only
//    0x14 status: limit removed, fast readout, acquisition state
//    other offsets: pslverr, writes dropped, reads zero
//
// frame timing
//    minimum period = region height * line time + fixed overhead
//    line time 20 normal, 12 fast, less a quarter with limit removed
//    the frame timer restarts at every frame start
//    a frame runs one minimum period latched at its start
//    free run starts the next frame once the paced period has passed
//
// states
//    wait acquisition: nothing happens until acquisition may start
//    wait frame: the only state in which a frame trigger counts
//    frame: exposure and readout, then frame_valid for one clock
//
// limitations
//    input_line_one must already be synchronous to pclk
//    clearing acquisition enable lets a running frame finish
//
// Local design decisions: the placing of the registers and the APB slave port.
`include "atc_defines.vh"
module atc_trigger_ctrl
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire input_line_one,
   output wire frame_start,
   output wire frame_active,
   output wire frame_valid,
   output wire readout_fast_active,
   output wire [2:0] acq_state
);
   // one-hot acquisition states
   localparam S_WACQ = 3'b001;
   localparam S_WFRM = 3'b010;
   localparam S_FRAME = 3'b100;

   // register file and apb answer
   reg [31:0] ctrl_r;
   reg [31:0] target_r;
   reg [15:0] region_r;
   reg [31:0] prdata_r;
   reg pslverr_r;
   reg acq_cmd_r;
   reg line_prev_r;

   // acquisition state and per-frame settings
   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [31:0] frame_len_r;
   reg fast_r;
   reg unlimit_r;
   reg frame_start_r;
   reg frame_valid_r;

   // combinational helpers
   reg [31:0] rd_mux;
   reg rd_hit;
   reg [7:0] line_cyc;
   reg [23:0] rows_cyc;
   reg [31:0] min_period;
   reg [31:0] eff_period;
   reg start_now;

   // decoded controls, strobes and timer view
   wire [31:0] elapsed;
   wire setup_ph;
   wire access_wr;
   wire cfg_fast;
   wire cfg_unlimit;
   wire acq_en;
   wire acq_trig_en;
   wire frm_trig_en;
   wire tgt_en;
   wire line_hi;
   wire line_edge;
   wire frame_end;
   wire wr_ctrl;
   wire wr_cmd;
   wire wr_target;
   wire wr_region;
   wire origin_ok;
   wire rise_seen;
   wire fall_seen;
   wire acq_go;
   wire pace_due;

   ////////////////////////////////////////////////////////////////////
   // configuration fields
   assign cfg_fast = ctrl_r[`ATC_CTRL_FAST];
   assign cfg_unlimit = ctrl_r[`ATC_CTRL_UNLIMIT];
   assign acq_en = ctrl_r[`ATC_CTRL_ACQ_EN];
   assign acq_trig_en = ctrl_r[`ATC_CTRL_ACQ_TRIG];
   assign frm_trig_en = ctrl_r[`ATC_CTRL_FRM_TRIG];
   assign tgt_en = ctrl_r[`ATC_CTRL_TGT_EN];

   ////////////////////////////////////////////////////////////////////
   // apb slave: zero wait states, data prepared in setup phase
   assign setup_ph = psel & ~penable;
   assign access_wr = psel & penable & pwrite;
   assign pready = 1'b1;
   assign prdata = prdata_r;
   assign pslverr = pslverr_r;

   // one write strobe per writable offset
   assign wr_ctrl = access_wr & (paddr == `ATC_OFS_CTRL);
   assign wr_cmd = access_wr & (paddr == `ATC_OFS_CMD);
   assign wr_target = access_wr & (paddr == `ATC_OFS_TARGET);
   assign wr_region = access_wr & (paddr == `ATC_OFS_REGION);

   // read decode of the register map
   always @*
   begin
      rd_hit = 1'b1;
      rd_mux = 32'h00000000;
      case (paddr)
         `ATC_OFS_CTRL: rd_mux = ctrl_r;
         `ATC_OFS_CMD: rd_mux = 32'h00000000;
         `ATC_OFS_TARGET: rd_mux = target_r;
         `ATC_OFS_REGION: rd_mux = {16'h0000, region_r};
         `ATC_OFS_ACHIEVE: rd_mux = min_period;
         `ATC_OFS_STATUS: rd_mux = {27'h0000000, unlimit_r, fast_r, state_r};
         default: rd_hit = 1'b0;
      endcase
   end

   // read data latched at setup, held through access
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_r <= 32'h00000000;
      else if (setup_ph)
         prdata_r <= pwrite ? 32'h00000000 : rd_mux;
   end

   // error flag for unmapped offsets, same timing as read data
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pslverr_r <= 1'b0;
      else if (setup_ph)
         pslverr_r <= ~rd_hit;
   end

   // control word, unused bits kept at zero
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl_r <= `ATC_CTRL_RST;
      else if (wr_ctrl)
         ctrl_r <= pwdata & `ATC_CTRL_MASK;
   end

   // target frame period in clock cycles
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         target_r <= `ATC_TARGET_RST;
      else if (wr_target)
         target_r <= pwdata;
   end

   // image region height, low half of the word
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         region_r <= `ATC_REGION_RST;
      else if (wr_region)
         region_r <= pwdata[15:0];
   end

   // software acquisition start: sticky until consumed, set beats clear
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         acq_cmd_r <= 1'b0;
      else if (wr_cmd && pwdata[0])
         acq_cmd_r <= 1'b1;
      else if (state_r == S_WACQ && state_nxt == S_WFRM)
         acq_cmd_r <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////
   // frame period from speed, limit state and region height
   always @*
   begin
      line_cyc = cfg_fast ? `ATC_LINE_FAST : `ATC_LINE_NORMAL;
      if (cfg_unlimit)
         line_cyc = line_cyc - {2'b00, line_cyc[7:2]};
      rows_cyc = {8'h00, region_r} * {16'h0000, line_cyc};
      min_period = {8'h00, rows_cyc} + `ATC_FRAME_OVERHEAD;
      if (tgt_en && target_r > min_period)
         eff_period = target_r;
      else
         eff_period = min_period;
   end

   ////////////////////////////////////////////////////////////////////
   // trigger input edge detection on input line one
   assign line_hi = input_line_one;
   assign origin_ok =
      (ctrl_r[`ATC_CTRL_ORIGIN_HI:`ATC_CTRL_ORIGIN_LO] == `ATC_ORIGIN_LINE_ONE);
   assign rise_seen = line_hi & ~line_prev_r;
   assign fall_seen = ~line_hi & line_prev_r;

   // selected edge, only from input line one
   assign line_edge = origin_ok
      & ((ctrl_r[`ATC_CTRL_EDGE] == `ATC_EDGE_RISING) ? rise_seen : fall_seen);

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         line_prev_r <= 1'b0;
      else
         line_prev_r <= line_hi;
   end

   ////////////////////////////////////////////////////////////////////
   // frame pacing timer
   atc_frame_timer u_timer
   (
      .pclk(pclk),
      .presetn(presetn),
      .start(start_now),
      .elapsed(elapsed)
   );

   // frame ends once its latched length has run
   assign frame_end = (state_r == S_FRAME) && (elapsed >= frame_len_r);

   // acquisition may start: no trigger needed, or command pending
   assign acq_go = acq_en & (~acq_trig_en | acq_cmd_r);

   // free-run pacing: paced period reached since last start
   assign pace_due = (elapsed >= eff_period);

   ////////////////////////////////////////////////////////////////////
   // acquisition state machine
   always @*
   begin
      state_nxt = state_r;
      start_now = 1'b0;
      case (state_r)
         S_WACQ:
         begin
            if (acq_go)
               state_nxt = S_WFRM;
         end
         S_WFRM:
         begin
            if (!acq_en)
               state_nxt = S_WACQ;
            else if (frm_trig_en)
               start_now = line_edge;
            else
               start_now = pace_due;
            if (start_now)
               state_nxt = S_FRAME;
         end
         S_FRAME:
         begin
            if (frame_end)
               state_nxt = acq_en ? S_WFRM : S_WACQ;
         end
         default:
            state_nxt = S_WACQ;
      endcase
   end

   // acquisition state register
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state_r <= S_WACQ;
      else
         state_r <= state_nxt;
   end

   // start and hand-over pulses, one clock each
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         frame_start_r <= 1'b0;
         frame_valid_r <= 1'b0;
      end
      else
      begin
         frame_start_r <= start_now;
         frame_valid_r <= frame_end;
      end
   end

   // settings latched at frame start so a running frame never changes
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         frame_len_r <= 32'h00000000;
         fast_r <= 1'b0;
         unlimit_r <= 1'b0;
      end
      else if (start_now)
      begin
         frame_len_r <= min_period;
         fast_r <= cfg_fast;
         unlimit_r <= cfg_unlimit;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs
   assign frame_start = frame_start_r;
   assign frame_active = (state_r == S_FRAME);
   assign frame_valid = frame_valid_r;
   assign readout_fast_active = fast_r;
   assign acq_state = state_r;
endmodule

// ### tb/atc_trigger_ctrl_props.sv
// checker for the trigger controller ports
// assumes binding onto atc_trigger_ctrl, one clock
module atc_trigger_ctrl_props
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire input_line_one,
   input wire frame_start,
   input wire frame_active,
   input wire frame_valid,
   input wire readout_fast_active,
   input wire [2:0] acq_state
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////
   // frame steps: held frame, then its end
   sequence s_hold; frame_active [*8]; endsequence
   sequence s_end; $past(frame_active) && !frame_active; endsequence
   property p_pready; pready; endproperty
   property p_onehot; $onehot(acq_state); endproperty
   property p_active; frame_active == acq_state[2]; endproperty
   property p_start; frame_start |-> acq_state == 3'b100 && $past(acq_state) == 3'b010; endproperty
   property p_frame; frame_start |-> s_hold; endproperty
   property p_valid; frame_valid |-> s_end; endproperty
   property p_pulse; frame_start |=> !frame_start; endproperty
   property p_fast; $changed(readout_fast_active) |-> frame_start || $past(frame_start); endproperty
   a_pready: assert property (p_pready) else $error("pready low");
   a_onehot: assert property (p_onehot) else $error("state not one-hot");
   a_active: assert property (p_active) else $error("frame_active off state");
   a_start: assert property (p_start) else $error("start outside wait");
   a_frame: assert property (p_frame) else $error("frame too short");
   a_valid: assert property (p_valid) else $error("valid not at frame end");
   a_pulse: assert property (p_pulse) else $error("start not a pulse");
   a_fast: assert property (p_fast) else $error("speed changed mid frame");
endmodule

// ### tb/atc_line_src.sv
// external trigger source on input line one
// assumes the bench calls pulse once per trigger edge it wants to send
module atc_line_src
(
   input wire pclk,
   output logic line
);
   timeunit 1ns;
   timeprecision 1ns;
   initial line = 1'b0;
   // one rising edge per call, low when idle
   task pulse(input int hi);
      @(posedge pclk);
      line <= 1'b1;
      repeat (hi) @(posedge pclk);
      line <= 1'b0;
   endtask
endmodule

// ### tb/atc_trigger_ctrl_tb_top.sv
// bench for the trigger controller: registers, free run, triggers
// assumes hw on the include path
`include "atc_defines.vh"
module atc_trigger_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, input_line_one, frame_start, frame_active, frame_valid;
   logic readout_fast_active;
   logic [2:0] acq_state;
   int n_mismatch = 0, comparisons = 0, cyc = 0, n_fs = 0, n_fv = 0, t_fs = 0;
   always #50 pclk = ~pclk;
   atc_trigger_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .input_line_one(input_line_one), .frame_start(frame_start),
      .frame_active(frame_active), .frame_valid(frame_valid),
      .readout_fast_active(readout_fast_active), .acq_state(acq_state));
   atc_line_src src (.pclk(pclk), .line(input_line_one));
   task final_report;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // cycle count, frame counters, timeout
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (frame_start === 1'b1)
      begin
         n_fs <= n_fs + 1;
         t_fs <= cyc;
      end
      if (frame_valid === 1'b1)
         n_fv <= n_fv + 1;
      if (cyc == 20000)
      begin
         n_mismatch++;
         final_report;
      end
   end
   ////////////////////////////////////////
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
      output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      chk(q, exp);
      chk({31'h0, e}, {31'h0, err});
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask
   task wait_fs;
      int a;
      a = n_fs;
      for (int i = 0; i < 2000 && n_fs == a; i++) @(posedge pclk);
   endtask
   task period(input int lo, input int hi);
      int t1;
      wait_fs;
      wait_fs;
      t1 = t_fs;
      wait_fs;
      chk({31'h0, t_fs - t1 >= lo && t_fs - t1 <= hi}, 32'h1);
   endtask
   ////////////////////////////////////////
   task test_regs;
      chk({29'h0, acq_state}, 32'h1);
      chk({31'h0, readout_fast_active}, 32'h0);
      rd(`ATC_OFS_CTRL, 32'h0, 1'b0);
      rd(`ATC_OFS_REGION, 32'h1e0, 1'b0);
      rd(`ATC_OFS_ACHIEVE, 32'h25c0, 1'b0);
      rd(8'h18, 32'h0, 1'b1);
      // fast readout probed with the region at its wake-up size
      wr(`ATC_OFS_CTRL, 32'h1);
      rd(`ATC_OFS_ACHIEVE, 32'h16c0, 1'b0);
      wr(`ATC_OFS_CTRL, 32'h0);
      wr(`ATC_OFS_REGION, 32'h4);
      rd(`ATC_OFS_ACHIEVE, 32'h90, 1'b0);
      wr(`ATC_OFS_CTRL, 32'h1);
      rd(`ATC_OFS_ACHIEVE, 32'h70, 1'b0);
      wr(`ATC_OFS_CTRL, 32'h3);
      rd(`ATC_OFS_ACHIEVE, 32'h64, 1'b0);
      wr(`ATC_OFS_CTRL, 32'h2);
      rd(`ATC_OFS_ACHIEVE, 32'h7c, 1'b0);
      wr(`ATC_OFS_REGION, 32'h8);
      rd(`ATC_OFS_ACHIEVE, 32'hb8, 1'b0);
      wr(`ATC_OFS_REGION, 32'h4);
      $display("test_regs done");
   endtask
   task test_free;
      wr(`ATC_OFS_CTRL, 32'h4);
      period(144, 146);
      wr(`ATC_OFS_CTRL, 32'h5);
      period(112, 114);
      chk({31'h0, readout_fast_active}, 32'h1);
      wr(`ATC_OFS_TARGET, 32'd300);
      wr(`ATC_OFS_CTRL, 32'h24);
      period(300, 302);
      wr(`ATC_OFS_TARGET, 32'd50);
      period(144, 146);
      $display("test_free done");
   endtask
   task test_trig;
      int a;
      int b;
      int t0;
      wr(`ATC_OFS_CTRL, 32'h14);
      repeat (400) @(posedge pclk);
      chk({29'h0, acq_state}, 32'h2);
      a = n_fs;
      b = n_fv;
      t0 = cyc;
      src.pulse(3);
      chk(n_fs - a, 32'h1);
      chk({31'h0, t_fs - t0 <= 4}, 32'h1);
      repeat (20) @(posedge pclk);
      src.pulse(3);
      repeat (200) @(posedge pclk);
      chk(n_fs - a, 32'h1);
      chk(n_fv - b, 32'h1);
      src.pulse(3);
      repeat (200) @(posedge pclk);
      chk(n_fs - a, 32'h2);
      chk(n_fv - b, 32'h2);
      // other origin never fires; falling edge when selected
      wr(`ATC_OFS_CTRL, 32'h114);
      src.pulse(3);
      repeat (20) @(posedge pclk);
      chk(n_fs - a, 32'h2);
      wr(`ATC_OFS_CTRL, 32'h54);
      src.pulse(3);
      chk(n_fs - a, 32'h2);
      repeat (4) @(posedge pclk);
      chk(n_fs - a, 32'h3);
      $display("test_trig done");
   endtask
   // acquisition start command, then a reset in mid-run
   task test_acq;
      int a;
      wr(`ATC_OFS_CTRL, 32'h0);
      repeat (300) @(posedge pclk);
      wr(`ATC_OFS_CTRL, 32'hc);
      repeat (20) @(posedge pclk);
      chk({29'h0, acq_state}, 32'h1);
      a = n_fs;
      wr(`ATC_OFS_CMD, 32'h1);
      wait_fs;
      chk(n_fs - a, 32'h1);
      rd(`ATC_OFS_CMD, 32'h0, 1'b0);
      wr(`ATC_OFS_CTRL, 32'hd);
      wait_fs;
      wait_fs;
      chk({31'h0, readout_fast_active}, 32'h1);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      chk({29'h0, acq_state}, 32'h1);
      chk({31'h0, readout_fast_active}, 32'h0);
      rd(`ATC_OFS_CTRL, 32'h0, 1'b0);
      $display("test_acq done");
   endtask
   // reset, then the scenarios in turn
   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      test_regs;
      test_free;
      test_trig;
      test_acq;
      final_report;
   end
endmodule
bind atc_trigger_ctrl atc_trigger_ctrl_props u_props (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .input_line_one(input_line_one),
   .frame_start(frame_start), .frame_active(frame_active), .frame_valid(frame_valid),
   .readout_fast_active(readout_fast_active), .acq_state(acq_state));
